// File: logic/rsm_ctrl.sv
/*
  Reference selection and operating mode controller, APB slave.
  Assumes ref_valid, ref_act, phase_locked, dpll_freq and jtag_tdo come from
  logic on pclk; protect_switch_pin is an asynchronous pin.
*/
// Implementation choices: the register addresses and the APB register port.
`include "rsm_regs.svh"

module rsm_ctrl #(
  parameter int TICK_CYCLES  = `TICK_CYC,
  parameter int STRAP_CYCLES = `STRAP_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [7:0]         ref_valid,
  input  wire logic [7:0]         ref_act,
  input  wire logic               phase_locked,
  input  wire logic [18:0]        dpll_freq,
  input  wire logic               protect_switch_pin,
  input  wire logic               jtag_tdo,
  output logic      [2:0]         sel_ref,
  output logic                    sel_ok,
  output rsm_pkg::rsm_state_t     op_state,
  output logic      [18:0]        hold_freq,
  output logic                    monitor_off,
  output logic                    scan_out,
  output logic      [31:0]        tol_cfg,
  output logic      [7:0]         phase_alarm
);
  import rsm_pkg::*;

  // Returns {found, index}; ties go to the lowest index
  function automatic logic [3:0] best_ref(input logic [7:0] cand, input logic [31:0] prio);
    logic [3:0] r;
    logic [3:0] bp;
    r  = 4'h0;
    bp = 4'hF;
    for (int i = 0; i < NREF; i++) begin
      if (cand[i] && prio[4*i +: 4] != 4'h0 && (!r[3] || prio[4*i +: 4] < bp)) begin
        r  = {1'b1, 3'(i)};
        bp = prio[4*i +: 4];
      end
    end
    return r;
  endfunction

  logic [7:0]  ctrl;
  logic [3:0]  ovr;
  logic        lost_flag;
  logic [31:0] prio;
  logic [18:0] man_freq;
  logic [18:0] hold_cap;
  rsm_state_t  fstate;
  rsm_state_t  next_state;
  logic        fsm_disq;
  logic [13:0] timer;
  logic [13:0] lockc;
  logic [20:0] tick_cnt;
  logic        tick;
  logic [24:0] strap_cnt;
  logic        strap_seen;
  logic        strap_done;
  logic        strap_mode;
  logic [7:0]  gap;
  logic        pin_s1;
  logic        pin_s2;

  // APB decode
  wire        acc       = psel & penable;
  wire        hit_ctrl  = paddr == `REG_CTRL;
  wire        hit_ovr   = paddr == `REG_OVERRIDE;
  wire        hit_stat  = paddr == `REG_STATUS;
  wire        hit_op    = paddr == `REG_OPSTATE;
  wire        hit_prio  = paddr == `REG_PRIORITY;
  wire        hit_tol   = paddr == `REG_TOLERANCE;
  wire        hit_disq  = paddr == `REG_DISQ;
  wire        hit_man   = paddr == `REG_MANFREQ;
  wire        hit_fst   = paddr == `REG_FSTATE;
  wire        mapped    = hit_ctrl | hit_ovr | hit_stat | hit_op | hit_prio | hit_tol |
                          hit_disq | hit_man | hit_fst;
  wire        wr        = acc & pready & pwrite & mapped;
  wire [31:0] rd_mux    = hit_ctrl ? {24'h000000, ctrl} :
                          hit_ovr  ? {28'h0000000, ovr} :
                          hit_stat ? {25'h0000000, lost_flag, 6'h00} :
                          hit_op   ? {24'h000000, sel_ok, sel_ref, 1'b0, op_state} :
                          hit_prio ? prio :
                          hit_tol  ? tol_cfg :
                          hit_disq ? {24'h000000, phase_alarm} :
                          hit_man  ? {13'h0000, man_freq} :
                          hit_fst  ? {29'h00000000, fstate} : 32'h00000000;

  // Selection
  wire        protect   = ctrl[`CTRL_PROTECT] | strap_mode;
  wire        auto_sel  = ovr == 4'h0 || ovr == 4'hF;
  wire [7:0]  cand      = ref_valid & ~phase_alarm;
  wire [7:0]  cur_mask  = 8'h01 << sel_ref;
  wire [3:0]  best      = best_ref(cand, prio);
  wire [3:0]  alt       = best_ref(cand & ~cur_mask, prio);
  wire [3:0]  cur_prio  = prio[4*sel_ref +: 4];
  wire        cur_good  = sel_ok & cand[sel_ref] & cur_prio != 4'h0;
  // Input three at [15:12], input four at [19:16]
  wire [2:0]  prot_idx  = pin_s2 ? (prio[15:12] == 4'h0 ? 3'h5 : 3'h3) :
                                   (prio[19:16] == 4'h0 ? 3'h6 : 3'h4);
  wire        gap_run   = sel_ok & ctrl[`CTRL_FASTEN] & ~protect & ~ref_act[sel_ref];
  wire        fast_evt  = gap_run & gap == `FAST_GAP - 8'h01;
  wire        fast_sw   = fast_evt & ~ctrl[`CTRL_IRQONLY];
  wire        better    = ctrl[`CTRL_REVERT] & best[3] & best[2:0] != sel_ref &
                          (best[3] && prio[4*best[2:0] +: 4] < cur_prio);
  wire        need_sw   = !cur_good | fast_sw;
  wire [2:0]  next_ref  = protect   ? prot_idx :
                          !auto_sel ? ovr[2:0] :
                          fast_sw   ? alt[2:0] :
                          need_sw   ? best[2:0] :
                          better    ? best[2:0] : sel_ref;
  wire        next_ok   = protect   ? 1'b1 :
                          !auto_sel ? ~ovr[3] :
                          fast_sw   ? alt[3] :
                          need_sw   ? best[3] : 1'b1;
  wire        sw_evt    = sel_ok & next_ok & next_ref != sel_ref;
  wire        qual      = lockc >= 14'(`LOCK_TICKS);
  wire        limit_hit = timer >= 14'(`LIMIT_TICKS);
  wire        limit_ovr = timer > 14'(`LIMIT_TICKS);
  wire [7:0]  disq_set  = (fsm_disq | fast_sw) ? cur_mask : 8'h00;
  wire [7:0]  disq_clr  = (wr & hit_disq) ? pwdata[7:0] : 8'h00;
  wire        lost_clr  = wr & hit_stat & pwdata[`STAT_LOST];

  always_comb begin
    next_state = op_state;
    fsm_disq   = 1'b0;
    if (protect) begin
      next_state = RSM_LOCKED;
    end else if (ctrl[`CTRL_FORCED]) begin
      next_state = fstate;
    end else begin
      case (op_state)
        RSM_FREE: begin
          if (sel_ok) next_state = RSM_PRELOCK;
        end
        RSM_PRELOCK: begin
          if (!sel_ok) begin
            next_state = RSM_FREE;
          end else if (qual) begin
            next_state = RSM_LOCKED;
          end else if (limit_hit) begin
            fsm_disq   = 1'b1;
            next_state = RSM_FREE;
          end
        end
        RSM_PRELOCK2: begin
          if (!sel_ok) begin
            next_state = RSM_HOLD;
          end else if (qual) begin
            next_state = RSM_LOCKED;
          end else if (limit_hit) begin
            fsm_disq   = 1'b1;
            next_state = RSM_HOLD;
          end
        end
        RSM_LOCKED: begin
          if (!sel_ok) begin
            next_state = RSM_HOLD;
          end else if (sw_evt) begin
            next_state = RSM_PRELOCK2;
          end else if (!phase_locked) begin
            next_state = RSM_LOSTPH;
          end
        end
        RSM_LOSTPH: begin
          if (!sel_ok) begin
            next_state = RSM_HOLD;
          end else if (qual) begin
            next_state = RSM_LOCKED;
          end else if (limit_ovr) begin
            fsm_disq   = 1'b1;
            next_state = alt[3] ? RSM_PRELOCK2 : RSM_HOLD;
          end
        end
        RSM_HOLD: begin
          if (sel_ok) next_state = RSM_PRELOCK2;
        end
        default: next_state = RSM_FREE;
      endcase
    end
  end

  // APB slave, one wait state so every output is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata  <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= `CTRL_RST;
      ovr      <= `OVR_RST;
      prio     <= `PRIO_RST;
      man_freq <= 19'h00000;
      fstate   <= RSM_FREE;
    end else if (ce && wr) begin
      if (hit_ctrl) ctrl <= pwdata[7:0];
      if (hit_ovr) ovr <= pwdata[3:0];
      if (hit_prio) prio <= pwdata;
      if (hit_man) man_freq <= pwdata[18:0];
      if (hit_fst) fstate <= rsm_state_t'(pwdata[2:0]);
    end
  end

  // Set beats clear for both sticky registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lost_flag   <= 1'b0;
      phase_alarm <= 8'h00;
    end else if (ce) begin
      lost_flag   <= fast_evt | (lost_flag & ~lost_clr);
      phase_alarm <= ((phase_alarm & ~disq_clr) & ref_valid) | disq_set;
    end
  end

  // Strap is caught after release; sync needs two edges to show the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1     <= 1'b0;
      pin_s2     <= 1'b0;
      strap_cnt  <= 25'h0000000;
      strap_seen <= 1'b0;
      strap_done <= 1'b0;
      strap_mode <= 1'b0;
    end else if (ce) begin
      pin_s1 <= protect_switch_pin;
      pin_s2 <= pin_s1;
      if (!strap_done) strap_cnt <= strap_cnt + 25'h0000001;
      if (strap_cnt == 25'h0000002) strap_seen <= pin_s2;
      if (!strap_done && strap_cnt == 25'(STRAP_CYCLES - 1)) begin
        strap_done <= 1'b1;
        strap_mode <= strap_seen & pin_s2;
      end
    end
  end

  // Software write still wins later; strap only changes the defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tol_cfg <= {4{`TOL_NARROW}};
    end else if (ce) begin
      if (wr && hit_tol) begin
        tol_cfg <= pwdata;
      end else if (!strap_done && strap_cnt == 25'(STRAP_CYCLES - 1) && strap_seen && pin_s2) begin
        tol_cfg <= {4{`TOL_WIDE}};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 21'h000000;
      tick     <= 1'b0;
    end else if (ce) begin
      tick     <= tick_cnt == 21'(TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == 21'(TICK_CYCLES - 1)) ? 21'h000000 : tick_cnt + 21'h000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer <= 14'h0000;
      lockc <= 14'h0000;
      gap   <= 8'h00;
    end else if (ce) begin
      if (next_state != op_state || sw_evt) timer <= 14'h0000;
      else if (tick && timer != 14'h3FFF) timer <= timer + 14'h0001;
      if (!phase_locked || sw_evt) lockc <= 14'h0000;
      else if (tick && !qual) lockc <= lockc + 14'h0001;
      if (!gap_run || sw_evt) gap <= 8'h00;
      else if (gap != `FAST_GAP) gap <= gap + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_state    <= RSM_FREE;
      sel_ref     <= 3'h0;
      sel_ok      <= 1'b0;
      hold_cap    <= 19'h00000;
      hold_freq   <= 19'h00000;
      monitor_off <= 1'b0;
      scan_out    <= 1'b0;
    end else if (ce) begin
      op_state    <= next_state;
      sel_ref     <= next_ref;
      sel_ok      <= next_ok;
      if (op_state == RSM_LOCKED) hold_cap <= dpll_freq;
      hold_freq   <= ctrl[`CTRL_MANHOLD] ? man_freq : hold_cap;
      monitor_off <= protect;
      scan_out    <= ctrl[`CTRL_SCANOUT] ? lost_flag : jtag_tdo;
    end
  end

endmodule

// File: logic/rsm_pkg.sv
/*
  Types for the reference selection and mode controller.
  Assumes nothing beyond the register header.
*/
package rsm_pkg;
  localparam int NREF = 8;

  // Gray along free-run, pre-locked, locked, lost-phase, holdover, pre-locked2
  typedef enum logic [2:0] {
    RSM_FREE     = 3'h0,
    RSM_PRELOCK  = 3'h1,
    RSM_LOCKED   = 3'h3,
    RSM_LOSTPH   = 3'h2,
    RSM_HOLD     = 3'h6,
    RSM_PRELOCK2 = 3'h7
  } rsm_state_t;
endpackage

// File: logic/rsm_regs.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  reference selection and mode controller. Assumes a 125 MHz pclk and APB.
*/
// Contract
// - Fast disqualify: short loss flags and switches
// - Fast loss may flag only, or also switch
// - Loss of locked reference sets status flag
// - Optionally mirror loss flag onto scan output
// - Non-revertive keeps valid current reference
// - Failed reference always causes a switch; code keeps it under override or protect mode
// - Override zero or all ones is automatic
// - Override resets to all ones
// - Protect mode from strap or software bit
// - Pin high picks three/five, low four/six
// - Strap widens switched input tolerance defaults
// - Zero priority swaps to partner input
// - Protect mode: monitors off, state reads locked
// - Automatic state control by default, forced optional
// - Free-run to pre-locked on selection
// - Pre-locked timeout disqualifies, back to free-run
// - Locked needs one second continuous phase lock
// - Lost-phase over limit disqualifies reference
// - After lost-phase: pre-locked2 or holdover
// - No replacement enters holdover with stored frequency
// - Manual-hold bit picks manual holdover frequency
// - Holdover to pre-locked2, timeout back to holdover
// - Lowest nonzero priority wins, zero excluded
// - Revertive switches to better priority reference
`ifndef RSM_REGS_SVH
`define RSM_REGS_SVH

`define REG_CTRL      8'h00
`define REG_OVERRIDE  8'h04
`define REG_STATUS    8'h08
`define REG_OPSTATE   8'h0C
`define REG_PRIORITY  8'h10
`define REG_TOLERANCE 8'h14
`define REG_DISQ      8'h18
`define REG_MANFREQ   8'h1C
`define REG_FSTATE    8'h20

`define CTRL_REVERT   0
`define CTRL_FORCED   1
`define CTRL_IRQONLY  2
`define CTRL_PROTECT  4
`define CTRL_FASTEN   5
`define CTRL_SCANOUT  6
`define CTRL_MANHOLD  7
`define STAT_LOST     6

`define CTRL_RST      8'h00
`define OVR_RST       4'hF
`define PRIO_RST      32'h87654321
`define TOL_NARROW    8'h17
`define TOL_WIDE      8'hC8

`define CLK_MHZ       125
`define TICK_MS       10
`define LOCK_QUAL_S   1
`define STATE_LIMIT_S 100
`define STRAP_WAIT_MS 251
`define TICK_CYC      (`TICK_MS * 1000 * `CLK_MHZ)
`define STRAP_CYC     (`STRAP_WAIT_MS * 1000 * `CLK_MHZ)
`define LOCK_TICKS    ((`LOCK_QUAL_S * 1000 + `TICK_MS - 1) / `TICK_MS)
`define LIMIT_TICKS   (`STATE_LIMIT_S * 1000 / `TICK_MS)
`define FAST_GAP      8'h10

`endif

// File: testbench/rsm_ctrl_monitor.sv
/*
  Port-level checker for rsm_ctrl, attached by bind.
  Assumes one pclk domain and the one-wait-state APB answer of the slave.
*/
module rsm_ctrl_monitor #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                phase_locked,
  input wire logic                sel_ok,
  input wire logic                monitor_off,
  input wire rsm_pkg::rsm_state_t op_state
);
  import rsm_pkg::*;
  // Tick phase is unknown, so one tick of slack on qualification
  localparam int QUAL = 99 * TICK_CYCLES;
  localparam int LIM  = 10001 * TICK_CYCLES + 4;
  logic [31:0] lock_run;
  logic [31:0] pl_cnt;
  wire         in_pre = (op_state == RSM_PRELOCK) || (op_state == RSM_PRELOCK2);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_run <= 32'h0;
      pl_cnt   <= 32'h0;
    end else begin
      lock_run <= phase_locked ? lock_run + 32'h1 : 32'h0;
      pl_cnt   <= in_pre ? pl_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_apb_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_slverr_pair: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside a completing access");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  a_protect_state: assert property (monitor_off && $past(monitor_off, 2) |-> op_state == RSM_LOCKED)
    else $error("protection mode not reporting locked");
  a_free_exit: assert property (op_state == RSM_FREE && sel_ok && !monitor_off |-> ##[1:3] op_state != RSM_FREE)
    else $error("free-run kept with a selection");
  a_lock_qual: assert property (op_state == RSM_LOCKED && $past(op_state) inside {RSM_PRELOCK, RSM_PRELOCK2, RSM_LOSTPH} && !monitor_off |-> lock_run >= QUAL)
    else $error("locked without one second of phase lock");
  a_lost_exit: assert property (op_state == RSM_LOCKED && !phase_locked && !monitor_off |-> ##[1:4] op_state != RSM_LOCKED)
    else $error("locked kept after phase loss");
  a_prelock_limit: assert property (pl_cnt <= LIM)
    else $error("pre-locked held past its limit");
endmodule

bind rsm_ctrl rsm_ctrl_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .phase_locked(phase_locked), .sel_ok(sel_ok),
  .monitor_off(monitor_off), .op_state(op_state)
);

// File: testbench/rsm_ref_model.sv
/*
  Reference input model: activity strobes and validity levels per input.
  Assumes the bench steers which inputs run and which are valid.
*/
module rsm_ref_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] run_mask,
  input  wire logic [7:0] good_mask,
  output logic      [7:0] ref_act,
  output logic      [7:0] ref_valid
);
  logic [1:0] phase;
  // One strobe in four edges; a stopped input stays low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase     <= 2'h0;
      ref_act   <= 8'h00;
      ref_valid <= 8'h00;
    end else begin
      phase     <= phase + 2'h1;
      ref_act   <= (phase == 2'h3) ? run_mask : 8'h00;
      ref_valid <= good_mask;
    end
  end
endmodule

// File: testbench/tb_rsm_ctrl.sv
/*
  Self-checking bench for rsm_ctrl with an APB master and reference model.
  Assumes short TICK and STRAP counts so the run stays brief.
*/
`include "rsm_regs.svh"
module tb_rsm_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import rsm_pkg::*;
  localparam int TICK = 2;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        phase_locked, pin, tdo, sel_ok, monitor_off, scan_out;
  logic [7:0]  paddr, run_mask, good_mask, ref_act, ref_valid, phase_alarm;
  logic [31:0] pwdata, prdata, tol_cfg, rd;
  logic [18:0] dpll_freq, hold_freq;
  logic [2:0]  sel_ref;
  rsm_state_t  op_state;
  int          err_total, checks_done, n;
  rsm_ctrl #(.TICK_CYCLES(TICK), .STRAP_CYCLES(20)) i_dut (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_valid(ref_valid), .ref_act(ref_act), .phase_locked(phase_locked),
    .dpll_freq(dpll_freq), .protect_switch_pin(pin), .jtag_tdo(tdo), .sel_ref(sel_ref),
    .sel_ok(sel_ok), .op_state(op_state), .hold_freq(hold_freq), .monitor_off(monitor_off),
    .scan_out(scan_out), .tol_cfg(tol_cfg), .phase_alarm(phase_alarm));
  rsm_ref_model i_refs (.pclk(pclk), .presetn(presetn), .run_mask(run_mask),
    .good_mask(good_mask), .ref_act(ref_act), .ref_valid(ref_valid));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Idle edge first, so psel is never assigned twice in one step
  // No cycle count assumed; only the watchdog ends a stuck wait
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  task wait_on(input string what, input bit is_sel, input logic [31:0] exp, input int lim);
    n = 0;
    while ((is_sel ? 32'(sel_ref) : 32'(op_state)) !== exp && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(what, is_sel ? 32'(sel_ref) : 32'(op_state), exp);
  endtask
  task t_reset;
    rdchk("ctrl", `REG_CTRL, 32'h0);
    rdchk("override", `REG_OVERRIDE, 32'hF);
    rdchk("priority", `REG_PRIORITY, 32'h87654321);
    rdchk("tolerance", `REG_TOLERANCE, 32'h17171717);
    rdchk("unmapped", 8'h40, 32'h0);
    chk("unmapped err", 32'(er), 32'h1);
    wait_on("first sel", 1, 32'h0, 10);
    wait_on("prelock", 0, 32'(RSM_PRELOCK), 10);
  endtask
  task t_lock;
    phase_locked <= 1'b1;
    wait_on("locked", 0, 32'(RSM_LOCKED), 100 * TICK + 50);
    chk("lock time", 32'(n >= 99 * TICK), 32'h1);
    phase_locked <= 1'b0;
    wait_on("lost", 0, 32'(RSM_LOSTPH), 10);
    phase_locked <= 1'b1;
  endtask
  task t_switch;
    good_mask <= 8'hFE;
    wait_on("failover", 1, 32'h1, 10);
    good_mask <= 8'hFF;
    repeat (30) @(posedge pclk);
    chk("non-revertive", 32'(sel_ref), 32'h1);
    wr(`REG_CTRL, 32'h1);
    wait_on("revert", 1, 32'h0, 10);
    wr(`REG_OVERRIDE, 32'h2);
    wait_on("forced", 1, 32'h2, 10);
    wr(`REG_OVERRIDE, 32'h0);
    wait_on("auto zero", 1, 32'h0, 10);
    wr(`REG_OVERRIDE, 32'hF);
    wr(`REG_CTRL, 32'h0);
  endtask
  task t_fast;
    wr(`REG_CTRL, 32'h60);
    run_mask <= 8'hFE;
    wait_on("fast switch", 1, 32'h1, 40);
    // Scan output is one flop behind the loss flag
    @(posedge pclk);
    chk("scan flag", 32'(scan_out), 32'h1);
    rdchk("loss status", `REG_STATUS, 32'h40);
    run_mask <= 8'hFF;
    wr(`REG_STATUS, 32'h40);
    wr(`REG_DISQ, 32'hFF);
    repeat (3) @(posedge pclk);
    chk("scan cleared", 32'(scan_out), 32'h0);
    wr(`REG_CTRL, 32'h64);
    run_mask <= 8'hFD;
    repeat (40) @(posedge pclk);
    chk("flag only keeps", 32'(sel_ref), 32'h1);
    rdchk("flag only status", `REG_STATUS, 32'h40);
    run_mask <= 8'hFF;
    wr(`REG_STATUS, 32'h40);
    wr(`REG_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk("scan normal", 32'(scan_out), 32'h1);
  endtask
  task t_hold;
    wait_on("relocked", 0, 32'(RSM_LOCKED), 100 * TICK + 50);
    good_mask <= 8'h00;
    wait_on("holdover", 0, 32'(RSM_HOLD), 10);
    chk("auto hold", 32'(hold_freq), 32'h0001ABCD);
    wr(`REG_MANFREQ, 32'h00002345);
    wr(`REG_CTRL, 32'h80);
    repeat (3) @(posedge pclk);
    chk("manual hold", 32'(hold_freq), 32'h00002345);
    wr(`REG_FSTATE, 32'(RSM_LOCKED));
    wr(`REG_CTRL, 32'h2);
    wait_on("forced state", 0, 32'(RSM_LOCKED), 10);
    wr(`REG_CTRL, 32'h0);
    wait_on("auto again", 0, 32'(RSM_HOLD), 10);
  endtask
  task t_timeout;
    phase_locked <= 1'b0;
    good_mask <= 8'hFF;
    wait_on("prelock2", 0, 32'(RSM_PRELOCK2), 10);
    n = 0;
    while (phase_alarm === 8'h00 && n < 10001 * TICK + 50) begin
      @(posedge pclk);
      n++;
    end
    chk("alarm time", 32'(n >= 9999 * TICK), 32'h1);
    chk("alarm raised", 32'(phase_alarm != 8'h00), 32'h1);
    phase_locked <= 1'b1;
  endtask
  task t_protect;
    wr(`REG_CTRL, 32'h10);
    pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("monitors off", 32'(monitor_off), 32'h1);
    chk("pin high sel", 32'(sel_ref), 32'h3);
    pin <= 1'b0;
    phase_locked <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("pin low sel", 32'(sel_ref), 32'h4);
    chk("always locked", 32'(op_state), 32'(RSM_LOCKED));
    wr(`REG_PRIORITY, 32'h87604321);
    repeat (3) @(posedge pclk);
    chk("partner sel", 32'(sel_ref), 32'h6);
    phase_locked <= 1'b1;
  endtask
  task t_strap;
    pin <= 1'b1;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (40) @(posedge pclk);
    chk("strap tolerance", tol_cfg, 32'hC8C8C8C8);
    chk("strap mode", 32'(monitor_off), 32'h1);
    chk("strap sel", 32'(sel_ref), 32'h3);
  endtask
  task give_verdict;
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Whole run is near 21k cycles; this bound only cuts a hang
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    give_verdict;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; phase_locked = 1'b0; pin = 1'b0; tdo = 1'b1;
    run_mask = 8'hFF; good_mask = 8'hFF; dpll_freq = 19'h1ABCD;
    err_total = 0; checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_lock;
    t_switch;
    t_fast;
    t_hold;
    t_timeout;
    t_protect;
    t_strap;
    give_verdict;
  end
endmodule
